// File: hw/acgr_regs.sv
// What this block does
// [R1] Power mode bits 1:0 give very-low-power at 00, low-power at 01, high-res otherwise.
// [R2] Gain bits 10:8 set channel 2 gain to two to the code, resetting to gain 1.
// [R3] Gain bits 6:4 set channel 1 gain to two to the code, resetting to gain 1.
// [R4] Gain bits 2:0 set channel 0 gain to two to the code, resetting to gain 1.
// [R5] The gain register sits at index 4, resets to zero, and takes zeros in reserved bits; the code stores reserved bits as written.
// [R6] A spare read/write word at index 5 resets to zero and is only written with zeros.
// [R7] The configuration register sits at index 6 and resets to 0600h.
// [R8] Configuration holds chop delay, chop enable, match select, threshold, length, enable.
// [R9] Chop delay waits two to the code plus one modulator periods before measuring.
// [R10] Match select zero fires on any qualifying channel, one only on all channels.
// [R11] Detection needs two to the threshold code exceedances within a window.
// [R12] Detect length picks a window of 128 up to 3584 conversion periods by code.
module acgr_regs #(
    parameter int ADDR_W  = 8,
    parameter int MOD_DIV = 2
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              convTick,
    input  wire logic [2:0]        chExceed,
    input  wire logic              measRequest,
    output logic                   powerVeryLow,
    output logic                   powerLow,
    output logic                   powerHighRes,
    output logic      [7:0]        ch0AmpGain,
    output logic      [7:0]        ch1AmpGain,
    output logic      [7:0]        ch2AmpGain,
    output logic                   chopEnable,
    output logic                   chopBusy,
    output logic                   measGo,
    output logic                   detectEnable,
    output logic                   currentDetect
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Word decode; misaligned or high addresses match nothing
    function automatic logic hitWord(input logic [ADDR_W-1:0] a, input logic [3:0] idx);
        hitWord = (a[ADDR_W-1:6] == '0) && (a[5:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    // Power-of-two gain code to one-hot gain factor
    function automatic logic [7:0] gainFactor(input logic [2:0] code);
        gainFactor = 8'(8'h01 << code);
    endfunction

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [1:0]  pwrSel_reg;
    logic [15:0] gain_reg;
    logic [15:0] spare_reg;
    logic [15:0] cfg_reg;
    logic        detFlag_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [15:0] modCnt_reg;
    logic        modTick_reg;

    logic [1:0]  pwrSel_next;
    logic [15:0] gain_next;
    logic [15:0] spare_next;
    logic [15:0] cfg_next;
    logic        detFlag_next;
    logic [31:0] prdata_next;

    logic        chopBusyInt;
    logic        measGoInt;
    logic        detPulse;

    acgr_cfg_if cfgBus ();

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------

    // Setup samples the address; the access edge with pready commits
    wire setupPhase = psel && !penable;
    wire accessDone = psel && penable && pready_reg;
    wire wrEn       = accessDone && pwrite;

    wire hitClock   = hitWord(paddr, acgr_pkg::IDX_CLOCK);
    wire hitGain    = hitWord(paddr, acgr_pkg::IDX_GAIN);   // R5
    wire hitSpare   = hitWord(paddr, acgr_pkg::IDX_SPARE);  // R6
    wire hitCfg     = hitWord(paddr, acgr_pkg::IDX_CFG);    // R7
    wire hitStatus  = hitWord(paddr, acgr_pkg::IDX_STATUS);
    wire mapped     = hitClock || hitGain || hitSpare || hitCfg || hitStatus;

    // Status word shows live sequencer state and the sticky detect flag
    wire [15:0] statusWord = 16'((16'(chopBusyInt) << acgr_pkg::STAT_BUSY_BIT) |
                                 (16'(detFlag_reg) << acgr_pkg::STAT_DET_BIT));

    // Read mux; bits above the sixteen stored ones read as zero
    wire [15:0] readWord = hitClock  ? {14'h0000, pwrSel_reg} :
                           hitGain   ? gain_reg :
                           hitSpare  ? spare_reg :
                           hitCfg    ? cfg_reg :
                           hitStatus ? statusWord : 16'h0000;

    assign prdata_next = setupPhase ? {16'h0000, readWord} : prdata_reg;

    // ------------------------------------------------------------
    // Write paths
    // ------------------------------------------------------------

    // Reserved bits of the gain, spare and config words are stored as written so software reads back its own value
    assign pwrSel_next = (wrEn && hitClock) ? pwdata[acgr_pkg::PWR_LSB +: 2] : pwrSel_reg;
    assign gain_next   = (wrEn && hitGain)  ? pwdata[15:0] : gain_reg;   // R5
    assign spare_next  = (wrEn && hitSpare) ? pwdata[15:0] : spare_reg;  // R6
    assign cfg_next    = (wrEn && hitCfg)   ? pwdata[15:0] : cfg_reg;    // R8

    // Write one to clear; a detection in the same cycle keeps the flag set
    assign detFlag_next = detPulse ||
                          (detFlag_reg && !(wrEn && hitStatus && pwdata[acgr_pkg::STAT_DET_BIT]));

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------

    // Configuration words
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pwrSel_reg  <= acgr_pkg::RST_PWR;   // R1
            gain_reg    <= acgr_pkg::RST_GAIN;  // R5
            spare_reg   <= acgr_pkg::RST_SPARE; // R6
            cfg_reg     <= acgr_pkg::RST_CFG;   // R7
            detFlag_reg <= 1'b0;
        end
        else
        begin
            pwrSel_reg  <= pwrSel_next;
            gain_reg    <= gain_next;
            spare_reg   <= spare_next;
            cfg_reg     <= cfg_next;
            detFlag_reg <= detFlag_next;
        end
    end

    // Bus answer; one access cycle, so no wait states ever
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata_reg  <= 32'h00000000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            prdata_reg  <= prdata_next;
            pready_reg  <= setupPhase;
            pslverr_reg <= setupPhase ? !mapped : pslverr_reg && !accessDone;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    // ------------------------------------------------------------
    // Modulator-rate enable
    // ------------------------------------------------------------

    // Divider stands in for the modulator clock; keeps one clock domain
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            modCnt_reg  <= 16'h0000;
            modTick_reg <= 1'b0;
        end
        else
        begin
            modCnt_reg  <= (modCnt_reg == 16'(MOD_DIV - 1)) ? 16'h0000 : modCnt_reg + 16'h0001;
            modTick_reg <= (modCnt_reg == 16'(MOD_DIV - 1));
        end
    end

    // ------------------------------------------------------------
    // Configuration fields to the sequencers
    // ------------------------------------------------------------
    assign cfgBus.chopDelay          = cfg_reg[acgr_pkg::CFG_DLY_LSB +: 4];   // R8
    assign cfgBus.chopEnable         = cfg_reg[acgr_pkg::CFG_CHOP_BIT];       // R8
    assign cfgBus.channelMatchSelect = cfg_reg[acgr_pkg::CFG_MATCH_BIT];      // R8
    assign cfgBus.thresholdCount     = cfg_reg[acgr_pkg::CFG_THR_LSB +: 3];   // R8
    assign cfgBus.detectLength       = cfg_reg[acgr_pkg::CFG_LEN_LSB +: 3];   // R8
    assign cfgBus.detectEnable       = cfg_reg[acgr_pkg::CFG_DET_BIT];        // R8
    assign cfgBus.modTick            = modTick_reg;

    acgr_chop_timer u_chop (
        .clk         (clk),
        .reset_n     (reset_n),
        .cfgBus      (cfgBus.chop),
        .measRequest (measRequest),
        .busy        (chopBusyInt),
        .measGo      (measGoInt)
    );

    acgr_detect u_detect (
        .clk      (clk),
        .reset_n  (reset_n),
        .cfgBus   (cfgBus.detect),
        .convTick (convTick),
        .chExceed (chExceed),
        .detPulse (detPulse)
    );

    // ------------------------------------------------------------
    // Decoded outputs
    // ------------------------------------------------------------

    // Registered one cycle after the field so every output is a flop
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            powerVeryLow  <= 1'b0;
            powerLow      <= 1'b0;
            powerHighRes  <= 1'b1;
            ch0AmpGain    <= 8'h01;
            ch1AmpGain    <= 8'h01;
            ch2AmpGain    <= 8'h01;
            chopEnable    <= 1'b0;
            detectEnable  <= 1'b0;
            chopBusy      <= 1'b0;
            measGo        <= 1'b0;
            currentDetect <= 1'b0;
        end
        else
        begin
            powerVeryLow  <= (pwrSel_reg == acgr_pkg::PWR_VERY_LOW);           // R1
            powerLow      <= (pwrSel_reg == acgr_pkg::PWR_LOW);                // R1
            powerHighRes  <= pwrSel_reg[1];                                    // R1
            ch0AmpGain    <= gainFactor(gain_reg[acgr_pkg::GAIN0_LSB +: 3]);   // R4
            ch1AmpGain    <= gainFactor(gain_reg[acgr_pkg::CHANNEL_GAIN_SELECT_LSB +: 3]);   // R3
            ch2AmpGain    <= gainFactor(gain_reg[acgr_pkg::GAIN2_LSB +: 3]);   // R2
            chopEnable    <= cfgBus.chopEnable;
            detectEnable  <= cfgBus.detectEnable;
            chopBusy      <= chopBusyInt;
            measGo        <= measGoInt;
            currentDetect <= detPulse;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    power_mode_a: assert property (@(posedge clk) disable iff (!reset_n) // R1
        (wrEn && hitClock) |-> ##2 (powerHighRes == $past(pwdata[1], 2) &&
            powerVeryLow == ($past(pwdata[1:0], 2) == 2'h0) &&
            powerLow == ($past(pwdata[1:0], 2) == 2'h1)))
        else $error("power mode decode wrong");
    gain_two_a: assert property (@(posedge clk) disable iff (!reset_n) // R2
        (wrEn && hitGain) |-> ##2 (ch2AmpGain == gainFactor($past(pwdata[10:8], 2))))
        else $error("channel 2 gain wrong");
    gain_one_a: assert property (@(posedge clk) disable iff (!reset_n) // R3
        (wrEn && hitGain) |-> ##2 (ch1AmpGain == gainFactor($past(pwdata[6:4], 2))))
        else $error("channel 1 gain wrong");
    gain_zero_a: assert property (@(posedge clk) disable iff (!reset_n) // R4
        (wrEn && hitGain) |-> ##2 (ch0AmpGain == gainFactor($past(pwdata[2:0], 2))))
        else $error("channel 0 gain wrong");
    gain_read_a: assert property (@(posedge clk) disable iff (!reset_n) // R5
        (setupPhase && hitGain) |=> (prdata == {16'h0000, $past(gain_reg)}))
        else $error("gain read back wrong");
    spare_read_a: assert property (@(posedge clk) disable iff (!reset_n) // R6
        (setupPhase && hitSpare) |=> (prdata == {16'h0000, $past(spare_reg)}))
        else $error("spare word read back wrong");
    cfg_fields_a: assert property (@(posedge clk) disable iff (!reset_n) // R8
        (wrEn && hitCfg) |=> (cfgBus.chopDelay == $past(pwdata[12:9]) &&
            cfgBus.detectLength == $past(pwdata[3:1]) && cfgBus.detectEnable == $past(pwdata[0])))
        else $error("configuration fields wrong");
    cfg_reset_a: assert property (@(posedge clk) // R7
        $rose(reset_n) |-> (cfg_reg == 16'h0600))
        else $error("configuration reset value wrong");
    unmapped_a: assert property (@(posedge clk) disable iff (!reset_n)
        (setupPhase && !mapped) |=> (pready && pslverr && prdata == 32'h00000000))
        else $error("unmapped access not refused");

endmodule

// File: hw/acgr_pkg.sv
package acgr_pkg;

    // ------------------------------------------------------------
    // Register word indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [3:0]  IDX_CLOCK       = 4'h3;
    localparam logic [3:0]  IDX_GAIN        = 4'h4;
    localparam logic [3:0]  IDX_SPARE       = 4'h5;
    localparam logic [3:0]  IDX_CFG         = 4'h6;
    localparam logic [3:0]  IDX_STATUS      = 4'h7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  RST_PWR         = 2'h2;
    localparam logic [15:0] RST_GAIN        = 16'h0000;
    localparam logic [15:0] RST_SPARE       = 16'h0000;
    localparam logic [15:0] RST_CFG         = 16'h0600;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          PWR_LSB         = 0;
    localparam int          GAIN2_LSB       = 8;
    localparam int          CHANNEL_GAIN_SELECT_LSB       = 4;
    localparam int          GAIN0_LSB       = 0;
    localparam int          CFG_DLY_LSB     = 9;
    localparam int          CFG_CHOP_BIT    = 8;
    localparam int          CFG_MATCH_BIT   = 7;
    localparam int          CFG_THR_LSB     = 4;
    localparam int          CFG_LEN_LSB     = 1;
    localparam int          CFG_DET_BIT     = 0;
    localparam int          STAT_BUSY_BIT   = 0;
    localparam int          STAT_DET_BIT    = 1;

    // Power mode codes; both upper codes mean high resolution
    localparam logic [1:0]  PWR_VERY_LOW    = 2'h0;
    localparam logic [1:0]  PWR_LOW         = 2'h1;

    // Detect window lengths in conversion periods, by code
    localparam logic [11:0] DET_LEN_TABLE [8] = '{12'h080, 12'h100, 12'h200, 12'h300,
                                                  12'h500, 12'h700, 12'hA00, 12'hE00};

    // Chop delay sequencer states, Gray along the path
    typedef enum logic [1:0] {
        CHOP_IDLE = 2'b00,
        CHOP_WAIT = 2'b01,
        CHOP_GO   = 2'b11
    } acgr_chop_state_e;

endpackage

// File: hw/acgr_cfg_if.sv
interface acgr_cfg_if;
    logic [3:0] chopDelay;
    logic       chopEnable;
    logic       channelMatchSelect;
    logic [2:0] thresholdCount;
    logic [2:0] detectLength;
    logic       detectEnable;
    logic       modTick;

    modport ctrl   (output chopDelay, chopEnable, channelMatchSelect, thresholdCount,
                    detectLength, detectEnable, modTick);
    modport chop   (input chopDelay, chopEnable, modTick);
    modport detect (input channelMatchSelect, thresholdCount, detectLength, detectEnable);
endinterface

// File: hw/acgr_chop_timer.sv
module acgr_chop_timer (
    input  wire logic  clk,
    input  wire logic  reset_n,
    acgr_cfg_if.chop   cfgBus,
    input  wire logic  measRequest,
    output logic       busy,
    output logic       measGo
);
    acgr_pkg::acgr_chop_state_e state_reg;
    acgr_pkg::acgr_chop_state_e state_next;
    logic [16:0]                waitCnt_reg;
    logic [17:0]                hlpTicks;

    // Wait is two to the power code plus one modulator periods
    wire [16:0] target   = 17'(17'h00002 << cfgBus.chopDelay);              // R9
    wire        lastTick = cfgBus.modTick && (waitCnt_reg == target - 17'h00001); // R9

    // Next state
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            acgr_pkg::CHOP_IDLE:
                if (measRequest)
                    state_next = cfgBus.chopEnable ? acgr_pkg::CHOP_WAIT : acgr_pkg::CHOP_GO;
            acgr_pkg::CHOP_WAIT:
                if (lastTick)
                    state_next = acgr_pkg::CHOP_GO;                          // R9
            acgr_pkg::CHOP_GO:
                state_next = acgr_pkg::CHOP_IDLE;
        endcase
    end

    // State, tick counter and registered outputs
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg   <= acgr_pkg::CHOP_IDLE;
            waitCnt_reg <= 17'h00000;
            busy        <= 1'b0;
            measGo      <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            waitCnt_reg <= (state_reg != acgr_pkg::CHOP_WAIT) ? 17'h00000 :
                           cfgBus.modTick ? waitCnt_reg + 17'h00001 : waitCnt_reg;
            busy        <= (state_next == acgr_pkg::CHOP_WAIT);
            measGo      <= (state_next == acgr_pkg::CHOP_GO);
        end
    end

    // Independent tick tally for checking the delay
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            hlpTicks <= 18'h00000;
        else
            hlpTicks <= !busy ? 18'h00000 : (cfgBus.modTick ? hlpTicks + 18'h00001 : hlpTicks);
    end

    chop_delay_a: assert property (@(posedge clk) disable iff (!reset_n) // R9
        (measGo && $past(busy)) |-> (hlpTicks == {1'b0, $past(target)}))
        else $error("chop delay length wrong");
endmodule

// File: hw/acgr_detect.sv
module acgr_detect (
    input  wire logic  clk,
    input  wire logic  reset_n,
    acgr_cfg_if.detect cfgBus,
    input  wire logic  convTick,
    input  wire logic  [2:0] chExceed,
    output logic       detPulse
);
    logic [11:0] winCnt_reg;
    logic [7:0]  hitCnt_reg;

    // Any or all channels must exceed, per match select
    wire         match   = cfgBus.channelMatchSelect ? (&chExceed) : (|chExceed); // R10
    wire [11:0]  len     = acgr_pkg::DET_LEN_TABLE[cfgBus.detectLength];         // R12
    wire [7:0]   need    = 8'(8'h01 << cfgBus.thresholdCount);                   // R11
    wire [7:0]   hitNext = hitCnt_reg + {7'h00, match};
    wire         trigger = match && (hitNext >= need);                          // R11
    wire         winEnd  = (winCnt_reg == len - 12'h001);                       // R12

    // Window and exceedance counters; the exceedance count restarts after each detection, both restart at window end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            winCnt_reg <= 12'h000;
            hitCnt_reg <= 8'h00;
            detPulse   <= 1'b0;
        end
        else if (!cfgBus.detectEnable)
        begin
            winCnt_reg <= 12'h000;
            hitCnt_reg <= 8'h00;
            detPulse   <= 1'b0;
        end
        else
        begin
            detPulse <= convTick && trigger;
            if (convTick)
            begin
                winCnt_reg <= winEnd ? 12'h000 : winCnt_reg + 12'h001;
                hitCnt_reg <= (winEnd || trigger) ? 8'h00 : hitNext;
            end
        end
    end

    det_match_a: assert property (@(posedge clk) disable iff (!reset_n) // R10
        detPulse |-> $past($countones(chExceed) >= (cfgBus.channelMatchSelect ? 3 : 1)))
        else $error("detection without qualifying channels");
    det_count_a: assert property (@(posedge clk) disable iff (!reset_n) // R11
        detPulse |-> ($past(hitNext) == $past(need)))
        else $error("detection at wrong exceedance count");
    det_window_a: assert property (@(posedge clk) disable iff (!reset_n) // R12
        (cfgBus.detectEnable && convTick && winEnd) |=> (winCnt_reg == 12'h000))
        else $error("detect window did not restart");
endmodule

// File: tb/acgr_regs_test.sv
module acgr_regs_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Stimulus, design and bookkeeping
    // ------------------------------------------------------------
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        convTick = 1'b0;
    logic [2:0]  chExceed = 3'h0;
    logic        measRequest = 1'b0;
    logic        powerVeryLow, powerLow, powerHighRes, chopEnable, chopBusy, measGo;
    logic        detectEnable, currentDetect;
    logic [7:0]  ch0AmpGain, ch1AmpGain, ch2AmpGain;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    logic [31:0] rd;
    logic        err;
    logic        got;
    int          n;

    // MOD_DIV of one keeps the chop waits short
    acgr_regs #(.ADDR_W(8), .MOD_DIV(1)) u_acgr_regs (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .convTick(convTick), .chExceed(chExceed),
        .measRequest(measRequest), .powerVeryLow(powerVeryLow), .powerLow(powerLow),
        .powerHighRes(powerHighRes), .ch0AmpGain(ch0AmpGain), .ch1AmpGain(ch1AmpGain),
        .ch2AmpGain(ch2AmpGain), .chopEnable(chopEnable), .chopBusy(chopBusy),
        .measGo(measGo), .detectEnable(detectEnable), .currentDetect(currentDetect));

    // Clock and hang guard; the whole run needs only a few thousand cycles
    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] addrOf(input logic [3:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] expected);
        checked++;
        if (seen !== expected)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, expected);
        end
    endtask

    // Values read right after the edge are the pre-edge register outputs
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No wait count is assumed; only the hang guard ends a stuck access
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One conversion tick, then watch a few cycles for a detection pulse
    task automatic tick(input logic [2:0] ex);
        @(posedge clk);
        convTick <= 1'b1;
        chExceed <= ex;
        @(posedge clk);
        convTick <= 1'b0;
        got = 1'b0;
        repeat (5)
        begin
            @(posedge clk);
            if (currentDetect === 1'b1)
                got = 1'b1;
        end
    endtask

    task automatic tally_and_finish();
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        chk({powerHighRes, ch0AmpGain, ch1AmpGain, ch2AmpGain}, 32'h01010101);
        apb(1'b0, addrOf(acgr_pkg::IDX_CLOCK), 32'h0);
        chk(rd, 32'h00000002);
        apb(1'b0, addrOf(acgr_pkg::IDX_GAIN), 32'h0);
        chk(rd, 32'h00000000);
        apb(1'b0, addrOf(acgr_pkg::IDX_SPARE), 32'h0);
        chk(rd, 32'h00000000);
        apb(1'b0, addrOf(acgr_pkg::IDX_CFG), 32'h0);
        chk(rd, 32'h00000600);
        // Every power code, both upper codes mean high resolution
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, addrOf(acgr_pkg::IDX_CLOCK), 32'(c));
            repeat (3) @(posedge clk);
            chk({powerVeryLow, powerLow, powerHighRes}, {c == 0, c == 1, c >= 2});
        end
        // Every gain code, channels offset so that each field is seen on its own
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, addrOf(acgr_pkg::IDX_GAIN), 32'({3'((c + 2) % 8), 1'b0,
                3'((c + 1) % 8), 1'b0, 3'(c)}));
            repeat (3) @(posedge clk);
            chk(ch0AmpGain, 32'(8'h01 << c));
            chk(ch1AmpGain, 32'(8'h01 << ((c + 1) % 8)));
            chk(ch2AmpGain, 32'(8'h01 << ((c + 2) % 8)));
            apb(1'b0, addrOf(acgr_pkg::IDX_GAIN), 32'h0);
            chk(rd[15:0], {5'h00, 3'((c + 2) % 8), 1'b0, 3'((c + 1) % 8), 1'b0, 3'(c)});
        end
        apb(1'b1, addrOf(acgr_pkg::IDX_SPARE), 32'h0);
        chk({rd[15:0], err}, 17'h00000);
        // Unmapped and misaligned places are refused and read zero
        apb(1'b1, 8'h20, 32'h0000FFFF);
        chk(err, 1'b1);
        apb(1'b0, 8'h11, 32'h0);
        chk({rd[15:0], err}, 17'h00001);
        // Config fields round trip with their copies
        apb(1'b1, addrOf(acgr_pkg::IDX_CFG), 32'h00001FFF);
        apb(1'b0, addrOf(acgr_pkg::IDX_CFG), 32'h0);
        chk(rd, 32'h00001FFF);
        repeat (2) @(posedge clk);
        chk({chopEnable, detectEnable}, 2'b11);
        // Chop wait for small codes, then with chop off
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, addrOf(acgr_pkg::IDX_CFG), 32'((c << 9) | 16'h0100));
            repeat (3) @(posedge clk);
            measRequest <= 1'b1;
            @(posedge clk);
            measRequest <= 1'b0;
            n = 0;
            for (int i = 0; i < 200 && measGo !== 1'b1; i++)
            begin
                @(posedge clk);
                n++;
                if (n == 2)
                    chk(chopBusy, 1'b1);
            end
            chk(n >= (2 << c) && n <= (2 << c) + 3, 1'b1);
        end
        apb(1'b1, addrOf(acgr_pkg::IDX_CFG), 32'h00000000);
        repeat (3) @(posedge clk);
        measRequest <= 1'b1;
        @(posedge clk);
        measRequest <= 1'b0;
        repeat (2) @(posedge clk);
        chk(measGo, 1'b1);
        // Detection: any channel, then all channels, then two hits needed
        apb(1'b1, addrOf(acgr_pkg::IDX_CFG), 32'h00000001);
        tick(3'b001);
        chk(got, 1'b1);
        apb(1'b0, addrOf(acgr_pkg::IDX_STATUS), 32'h0);
        chk(rd[acgr_pkg::STAT_DET_BIT], 1'b1);
        apb(1'b1, addrOf(acgr_pkg::IDX_STATUS), 32'h00000002);
        apb(1'b0, addrOf(acgr_pkg::IDX_STATUS), 32'h0);
        chk(rd[acgr_pkg::STAT_DET_BIT], 1'b0);
        apb(1'b1, addrOf(acgr_pkg::IDX_CFG), 32'h00000081);
        tick(3'b011);
        chk(got, 1'b0);
        tick(3'b111);
        chk(got, 1'b1);
        apb(1'b1, addrOf(acgr_pkg::IDX_CFG), 32'h00000011);
        tick(3'b100);
        chk(got, 1'b0);
        tick(3'b010);
        chk(got, 1'b1);
        // Disabled detection ignores hits
        apb(1'b1, addrOf(acgr_pkg::IDX_CFG), 32'h00000000);
        tick(3'b111);
        chk(got, 1'b0);
        // Window of 128 periods: hits on its first and last tick pair up, across the end not
        apb(1'b1, addrOf(acgr_pkg::IDX_CFG), 32'h00000011);
        tick(3'b001);
        repeat (126) tick(3'b000);
        tick(3'b001);
        chk(got, 1'b1);
        tick(3'b001);
        repeat (127) tick(3'b000);
        tick(3'b001);
        chk(got, 1'b0);
        tally_and_finish();
    end
endmodule
